// ==== src/acr_defs.svh ====
// Constants of the converter configuration register bank: offsets,
// field positions, reset values and serial frame counts.
// Assumes inclusion by bare name from the bank's source files.
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// Register offsets
`define ACR_ADDR_PORT 8'h00
`define ACR_ADDR_ID 8'h01
`define ACR_ADDR_GRADE 8'h02
`define ACR_ADDR_CHSEL 8'h05
`define ACR_ADDR_PWR 8'h08
`define ACR_ADDR_GCLK 8'h09
`define ACR_ADDR_CDIV 8'h0B
`define ACR_ADDR_XFER 8'hFF

// Field positions
`define ACR_PORT_LSB_HI 6
`define ACR_PORT_LSB_LO 1
`define ACR_PORT_SRST_HI 5
`define ACR_PORT_SRST_LO 2
`define ACR_PORT_FIXED 8'h18
`define ACR_GRADE_LSB 4
`define ACR_PWR_FN_BIT 5
`define ACR_GCLK_DCS_BIT 0
`define ACR_XFER_BIT 0

// Reset values
`define ACR_RST_CHSEL 2'h3
`define ACR_RST_PWR 3'h0
`define ACR_RST_GCLK 1'h1
`define ACR_RST_CDIV 6'h00

// Power mode codes and frame counts
`define ACR_MODE_FULL 2'h1
`define ACR_MODE_STBY 2'h2
`define ACR_INSTR_LAST 4'hF
`define ACR_BYTE_LAST 4'h7
`define ACR_LEN_STREAM 2'h3

`endif

// ==== src/acr_pkg.sv ====
// Types shared by the converter configuration register bank.
// Assumes nothing of its surroundings.
package acr_pkg;

  // Serial frame phase
  typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_DONE} acr_state_e;

endpackage

// ==== src/acr_bank.sv ====
// Configuration register bank of a dual-channel converter, reached over
// a three-wire serial port. Assumes the serial clock runs far slower than
// clk_sys_i (at least 8 system clocks per serial clock phase).
`timescale 1ns/1ps
`default_nettype none
`include "acr_defs.svh"

// Functional notes
// (RULE1) Host avoids unmapped addresses and bits.
// (RULE2) Bit order select mirrored at bits 6,1.
// (RULE3) Soft reset mirrored 5,2; fixed 4,3.
// (RULE4) Read-only two-bit speed grade field.
// (RULE5) Channel select bits A/B, reset 0x03.
// (RULE6) Transfer bit copies staged to active.
// (RULE7) Bit 5 picks power-down pin function.
// (RULE8) Global clock bit 0 enables stabilizer.
// (RULE9) Divide ratio field n divides by n+1.
// (RULE10) Phase field n delays n input clocks.
// (RULE11) Nonzero ratio forces stabilizer on.
// (RULE12) Shadow writes wait; transfer bit self-clears.
// (RULE13) Both selected: write both, read A.
// (RULE14) Most significant bit first after reset.
// (RULE15) Soft reset self-clears, restores defaults.
module acr_bank #(
  parameter logic [7:0] PART_IDENTIFIER = 8'h5A,    // Arbitrary value
  parameter logic [1:0] SPEED_GRADE = 2'h2  // Arbitrary value
) (
  input wire logic clk_sys_i,         // System clock, 25 MHz
  input wire logic rstn_i,            // Synchronous reset, active low
  input wire logic sclk_i,            // Serial clock pin
  input wire logic csb_n_i,           // Serial chip select pin, low active
  input wire logic sdio_i,            // Serial data pin, input side
  output logic sdio_o,                // Serial data pin, output side
  output logic sdio_oe_o,             // Serial data pin drive enable
  input wire logic pdwn_i,            // External power-down pin
  output logic [1:0] pd_full_o,       // Full power-down, per channel
  output logic [1:0] pd_stby_o,       // Standby, per channel
  output logic dcs_en_o,              // Duty cycle stabilizer active
  output logic [2:0] clk_div_ratio_o, // Divide by value plus one
  output logic [2:0] clk_div_phase_o  // Divider phase delay in clocks
);

  // Pin vector positions and internal state
  localparam int P_CSB = 0, P_SCLK = 1, P_SDIO = 2, P_PDWN = 3;
  logic [3:0] s1_q, s2_q, s3_q, pin_q, pin_prev_q, cnt_q;
  logic sclk_rise, sclk_fall, rd_q, wr_stb, lsb_q, srst_q, commit_q;
  acr_pkg::acr_state_e state_q;
  logic [15:0] sh_q, sh_d;
  logic [1:0] len_q, nbyte_q, chsel_q;
  logic [12:0] addr_q;
  logic [7:0] wr_data, rd_byte;
  logic [2:0] pm_sh_q [2], pm_act_q [2];
  logic gclk_sh_q, gclk_act_q;
  logic [5:0] cdiv_sh_q, cdiv_act_q;

  // Three-stage pin synchroniser with agreement filter
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      {s1_q, s2_q, s3_q, pin_q, pin_prev_q} <= {5{4'h1}};
    end
    else
    begin
      s1_q <= {pdwn_i, sdio_i, sclk_i, csb_n_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 4; i++)
        if (s2_q[i] == s3_q[i])
          pin_q[i] <= s3_q[i];
      pin_prev_q <= pin_q;
    end
  end

  assign sclk_rise = pin_q[P_SCLK] & ~pin_prev_q[P_SCLK] & ~pin_q[P_CSB];
  assign sclk_fall = ~pin_q[P_SCLK] & pin_prev_q[P_SCLK] & ~pin_q[P_CSB];

  // (RULE14) Shift order follows select
  assign sh_d = lsb_q ? {pin_q[P_SDIO], sh_q[15:1]}
                      : {sh_q[14:0], pin_q[P_SDIO]};
  assign wr_data = lsb_q ? sh_d[15:8] : sh_d[7:0];
  assign wr_stb = sclk_rise & (state_q == acr_pkg::ST_DATA) & ~rd_q &
                  (cnt_q == `ACR_BYTE_LAST) & (addr_q[12:8] == 5'h00);

  // Serial frame: instruction word, then data bytes
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      state_q <= acr_pkg::ST_INSTR;
      {cnt_q, nbyte_q, len_q, rd_q} <= 9'h000;
      {sh_q, addr_q} <= 29'h00000000;
    end
    else if (pin_q[P_CSB])
    begin
      state_q <= acr_pkg::ST_INSTR;
      {cnt_q, nbyte_q} <= 6'h00;
    end
    else if (sclk_rise)
    begin
      sh_q <= sh_d;
      cnt_q <= cnt_q + 4'h1;
      unique case (state_q)
        acr_pkg::ST_INSTR:
          if (cnt_q == `ACR_INSTR_LAST)
          begin
            state_q <= acr_pkg::ST_DATA;
            rd_q <= sh_d[15];
            len_q <= sh_d[14:13];
            addr_q <= sh_d[12:0];
          end
        acr_pkg::ST_DATA:
          if (cnt_q == `ACR_BYTE_LAST)
          begin
            cnt_q <= 4'h0;
            addr_q <= addr_q + 13'h0001;
            nbyte_q <= nbyte_q + 2'h1;
            if (len_q != `ACR_LEN_STREAM && nbyte_q == len_q)
              state_q <= acr_pkg::ST_DONE;
          end
        acr_pkg::ST_DONE:
          cnt_q <= 4'h0;
      endcase
    end
  end

  // Read data multiplexer; unmapped addresses read zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (addr_q[12:8] == 5'h00)
    begin
      unique case (addr_q[7:0])
        // (RULE2) (RULE3) Mirrored nibbles
        `ACR_ADDR_PORT: rd_byte = `ACR_PORT_FIXED |
          {1'b0, lsb_q, srst_q, 2'h0, srst_q, lsb_q, 1'b0};
        `ACR_ADDR_ID: rd_byte = PART_IDENTIFIER;
        // (RULE4) Speed grade field
        `ACR_ADDR_GRADE: rd_byte = {2'h0, SPEED_GRADE, 4'h0};
        `ACR_ADDR_CHSEL: rd_byte = {6'h00, chsel_q};
        // (RULE13) Channel A wins reads
        `ACR_ADDR_PWR: rd_byte = chsel_q[0]
          ? {2'h0, pm_sh_q[0][2], 3'h0, pm_sh_q[0][1:0]}
          : {2'h0, pm_sh_q[1][2], 3'h0, pm_sh_q[1][1:0]};
        `ACR_ADDR_GCLK: rd_byte = {7'h00, gclk_sh_q};
        `ACR_ADDR_CDIV: rd_byte = {2'h0, cdiv_sh_q};
        `ACR_ADDR_XFER: rd_byte = {7'h00, commit_q};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Readback bit driven after each falling serial clock
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      {sdio_o, sdio_oe_o} <= 2'h0;
    end
    else
    begin
      sdio_oe_o <= ~pin_q[P_CSB] & rd_q & (state_q == acr_pkg::ST_DATA);
      if (sclk_fall)
        sdio_o <= lsb_q ? rd_byte[cnt_q[2:0]]
                        : rd_byte[3'h7 - cnt_q[2:0]];
    end
  end

  // (RULE15) Soft reset pulses one cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      srst_q <= 1'b0;
    else
      srst_q <= wr_stb & (addr_q[7:0] == `ACR_ADDR_PORT) &
                (wr_data[`ACR_PORT_SRST_HI] | wr_data[`ACR_PORT_SRST_LO]);
  end

  // Staged register writes
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || srst_q)
    begin
      {lsb_q, commit_q} <= 2'h0;
      chsel_q <= `ACR_RST_CHSEL;
      pm_sh_q <= '{`ACR_RST_PWR, `ACR_RST_PWR};
      gclk_sh_q <= `ACR_RST_GCLK;
      cdiv_sh_q <= `ACR_RST_CDIV;
    end
    else
    begin
      // (RULE12) Transfer bit clears after one cycle
      commit_q <= wr_stb & (addr_q[7:0] == `ACR_ADDR_XFER) &
                  wr_data[`ACR_XFER_BIT];
      if (wr_stb)
      begin
        unique case (addr_q[7:0])
          // (RULE2) Either mirror sets order
          `ACR_ADDR_PORT: lsb_q <= wr_data[`ACR_PORT_LSB_HI] |
                                   wr_data[`ACR_PORT_LSB_LO];
          // (RULE5) Channel target select
          `ACR_ADDR_CHSEL: chsel_q <= wr_data[1:0];
          `ACR_ADDR_PWR:
            // (RULE13) Write each selected channel
            for (int c = 0; c < 2; c++)
              if (chsel_q[c])
                pm_sh_q[c] <= {wr_data[`ACR_PWR_FN_BIT], wr_data[1:0]};
          `ACR_ADDR_GCLK: gclk_sh_q <= wr_data[`ACR_GCLK_DCS_BIT];
          `ACR_ADDR_CDIV: cdiv_sh_q <= wr_data[5:0];
          default: ;
        endcase
      end
    end
  end

  // (RULE6) (RULE12) Commit staged values together
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || srst_q)
    begin
      pm_act_q <= '{`ACR_RST_PWR, `ACR_RST_PWR};
      gclk_act_q <= `ACR_RST_GCLK;
      cdiv_act_q <= `ACR_RST_CDIV;
    end
    else if (commit_q)
    begin
      pm_act_q <= pm_sh_q;
      gclk_act_q <= gclk_sh_q;
      cdiv_act_q <= cdiv_sh_q;
    end
  end

  // Converter-side control outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      {pd_full_o, pd_stby_o} <= 4'h0;
      dcs_en_o <= 1'b1;
      {clk_div_ratio_o, clk_div_phase_o} <= 6'h00;
    end
    else
    begin
      // (RULE7) Pin function per channel
      for (int c = 0; c < 2; c++)
      begin
        pd_full_o[c] <= (pin_q[P_PDWN] & ~pm_act_q[c][2]) |
                        (pm_act_q[c][1:0] == `ACR_MODE_FULL);
        pd_stby_o[c] <= (pin_q[P_PDWN] & pm_act_q[c][2]) |
                        (pm_act_q[c][1:0] == `ACR_MODE_STBY);
      end
      // (RULE8) (RULE11) Stabilizer enable or forced
      dcs_en_o <= gclk_act_q | (cdiv_act_q[2:0] != 3'h0);
      // (RULE9) Divide ratio field
      clk_div_ratio_o <= cdiv_act_q[2:0];
      // (RULE10) Phase delay field
      clk_div_phase_o <= cdiv_act_q[5:3];
    end
  end

  a_port_mirror: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    addr_q == 13'h0000 |-> rd_byte[6] == rd_byte[1] && rd_byte[5] ==
    rd_byte[2] && rd_byte[4:3] == 2'h3 && !rd_byte[7] && !rd_byte[0])
    else $error("port config mirror broken"); // (RULE2) (RULE3)
  a_grade_field: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    addr_q == 13'h0002 |-> rd_byte == {2'h0, SPEED_GRADE, 4'h0})
    else $error("speed grade read wrong"); // (RULE4)
  a_chsel_reset: assert property (@(posedge clk_sys_i)
    !rstn_i |=> chsel_q == 2'h3 && !lsb_q && !commit_q)
    else $error("reset values wrong"); // (RULE5) (RULE14)
  a_commit_copy: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i || srst_q) commit_q |=> cdiv_act_q ==
    $past(cdiv_sh_q) && gclk_act_q == $past(gclk_sh_q))
    else $error("transfer did not copy"); // (RULE6)
  a_shadow_hold: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i || srst_q)
    !commit_q |=> $stable(cdiv_act_q) && $stable(gclk_act_q))
    else $error("active changed without transfer"); // (RULE12)
  a_dcs_forced: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cdiv_act_q[2:0] != 3'h0 ##1 $stable(cdiv_act_q) |-> dcs_en_o)
    else $error("stabilizer not forced"); // (RULE11)
  a_div_fields: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ##1 clk_div_ratio_o == $past(cdiv_act_q[2:0]) &&
    clk_div_phase_o == $past(cdiv_act_q[5:3]))
    else $error("divider fields wrong"); // (RULE9) (RULE10)
  a_pin_select: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    pin_q[P_PDWN] && pm_act_q[0] == 3'h4 |=> pd_stby_o[0] && !pd_full_o[0])
    else $error("pin function not standby"); // (RULE7)
  a_srst_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    srst_q |=> !srst_q && chsel_q == 2'h3 && gclk_act_q)
    else $error("soft reset did not clear"); // (RULE15)
  a_both_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wr_stb && addr_q == 13'h0008 && chsel_q == 2'h3 |=>
    pm_sh_q[0] == pm_sh_q[1])
    else $error("both channels not written"); // (RULE13)
endmodule
`default_nettype wire

// ==== bench/acr_host.sv ====
// Serial host model: sends frames of a 16-bit instruction and one byte.
// Assumes it shares clk_sys_i with the bank and that the bench resolves
// the data pin level from both drivers.
`timescale 1ns/1ps
`default_nettype none
module acr_host #(
  parameter int HALF = 10
) (
  input wire logic clk_sys_i, // System clock
  input wire logic line_i,    // Resolved data pin level
  output logic sclk_o,        // Serial clock, idle low
  output logic csb_n_o,       // Chip select, low active
  output logic sdio_o         // Host drive of the data pin
);
  logic lsb_first;

  // Idle pins; the bench sets the bit order
  initial
  begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdio_o = 1'b0;
    lsb_first = 1'b0;
  end

  // One serial clock phase
  task automatic half();
    repeat (HALF) @(negedge clk_sys_i);
  endtask

  // caller picks the address and data
  task automatic frame(input logic [15:0] ins, input logic [7:0] wd,
                       output logic [7:0] rd);
    int i;
    int k;
    logic [23:0] v;
    v = {ins, wd};
    rd = 8'h00;
    @(negedge clk_sys_i);
    csb_n_o = 1'b0;
    half();
    for (i = 0; i < 24; i++)
    begin
      if (i < 16)
        k = lsb_first ? i + 8 : 23 - i;
      else
        k = lsb_first ? i - 16 : 23 - i;
      // Released pin toggles so a stale level never matches
      if (ins[15] && i >= 16)
        sdio_o = ~sdio_o;
      else
        sdio_o = v[k];
      half();
      if (i >= 16)
        rd[k] = line_i;
      sclk_o = 1'b1;
      half();
      sclk_o = 1'b0;
    end
    half();
    csb_n_o = 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_adc_config_register_bank.sv ====
// Bench for the converter configuration register bank.
// Assumes the host model drives frames and the bench resolves the pin.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_config_register_bank;
  // Arbitrary identity values
  localparam logic [7:0] ID = 8'hA7;
  localparam logic [1:0] SG = 2'h1;
  logic clk_sys_i;
  logic rstn_i;
  logic pdwn_i;
  logic sclk;
  logic csb_n;
  logic hsdio;
  logic sdio_o;
  logic sdio_oe_o;
  logic dcs_en_o;
  logic [1:0] pd_full_o;
  logic [1:0] pd_stby_o;
  logic [2:0] ratio;
  logic [2:0] phase;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int i;
  logic [7:0] ra [9] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h08, 8'h09,
                         8'h0B, 8'hFF, 8'h03};
  logic [7:0] re [9] = '{8'h18, ID, {2'b00, SG, 4'h0}, 8'h03, 8'h00,
                         8'h01, 8'h00, 8'h00, 8'h00};
  // Pin level seen by both ends
  wire logic line = sdio_oe_o ? sdio_o : hsdio;

  acr_bank #(.PART_IDENTIFIER(ID), .SPEED_GRADE(SG)) DUT (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sclk_i(sclk),
    .csb_n_i(csb_n), .sdio_i(line), .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o), .pdwn_i(pdwn_i), .pd_full_o(pd_full_o),
    .pd_stby_o(pd_stby_o), .dcs_en_o(dcs_en_o),
    .clk_div_ratio_o(ratio), .clk_div_phase_o(phase));

  acr_host host (.clk_sys_i(clk_sys_i), .line_i(line), .sclk_o(sclk),
    .csb_n_o(csb_n), .sdio_o(hsdio));

  // Clock, 40 ns period
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.frame({8'h00, a}, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.frame({8'h80, a}, 8'h00, r);
    chk(r, e);
  endtask

  // Clock outputs packed as {0, stabilizer, phase, ratio}
  task automatic outs(input logic [7:0] e);
    chk({1'b0, dcs_en_o, phase, ratio}, e);
  endtask

  task automatic pins(input logic [7:0] e);
    repeat (8) @(negedge clk_sys_i);
    chk({4'h0, pd_full_o, pd_stby_o}, e);
  endtask

  // Test sequence
  initial
  begin
    rstn_i = 1'b0;
    pdwn_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    outs(8'h40);
    for (i = 0; i < 9; i++)
      rd(ra[i], re[i]);
    $display("test reset done");
    wr(8'h09, 8'h00);
    wr(8'h0B, 8'h09);
    outs(8'h40);
    rd(8'h0B, 8'h09);
    wr(8'hFF, 8'h01);
    outs(8'h49);
    rd(8'hFF, 8'h00);
    wr(8'h0B, 8'h3F);
    wr(8'hFF, 8'h01);
    outs(8'h7F);
    wr(8'h0B, 8'h00);
    wr(8'hFF, 8'h01);
    outs(8'h00);
    wr(8'h09, 8'h01);
    wr(8'hFF, 8'h01);
    outs(8'h40);
    $display("test clock done");
    wr(8'h05, 8'h01);
    wr(8'h08, 8'h20);
    wr(8'h05, 8'h02);
    wr(8'h08, 8'h00);
    wr(8'h05, 8'h03);
    wr(8'hFF, 8'h01);
    pdwn_i = 1'b1;
    pins(8'h09);
    rd(8'h08, 8'h20);
    pdwn_i = 1'b0;
    pins(8'h00);
    wr(8'h08, 8'h01);
    wr(8'hFF, 8'h01);
    pins(8'h0C);
    wr(8'h08, 8'h02);
    wr(8'hFF, 8'h01);
    pins(8'h03);
    $display("test power done");
    wr(8'h00, 8'h42);
    host.lsb_first = 1'b1;
    rd(8'h05, 8'h03);
    rd(8'h00, 8'h5A);
    wr(8'h00, 8'h18);
    host.lsb_first = 1'b0;
    rd(8'h00, 8'h18);
    $display("test order done");
    wr(8'h05, 8'h01);
    wr(8'h00, 8'h3C);
    rd(8'h00, 8'h18);
    rd(8'h05, 8'h03);
    rd(8'h08, 8'h00);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
